// file: verilog/rf_transmitter_control.sv
// Transmitter control register bank with AXI4-Lite slave and antenna output logic
//
// Design decision made here: the AXI4-Lite register port.

// Function
// RL1: Modulator input chosen among low, high, internal encoder, external pin.
// RL2: Forcing full ASK kills carrier while modulating, ignoring modulation conductance.
// RL3: Second output carrier inverted when the inversion bit reads zero.
// RL4: Continuous-wave bit set gives unmodulated second carrier; clear enables modulation.
// RL5: Second output carries modulated carrier when enabled, constant level otherwise.
// RL6: First output carries modulated carrier when enabled, constant level otherwise.
// RL7: Six-bit carrier conductance sets driver conductance when not modulating.
// RL8: Six-bit modulation conductance used while modulating unless full ASK forced.
// RL9: Software keeps reserved bits at their documented values.
// RL10: Setting the single pulse bit forces one modulation pulse.
// RL11: Single pulse bit stays set until software writes zero.
// RL12: Three-bit encoder rate field selects encoder clock rate; 111 reserved.
// RL13: Three-bit coding field selects bit coding; 010 and 011 reserved.
// RL14: Reset values 58h, 3Fh, 3Fh and 19h.
// RL15: Register writes reach the outputs on the next clock cycle; the antenna outputs follow one cycle after the register.
module rf_transmitter_control #(
    parameter int PULSE_CYCLES = rf_tx_pkg::PULSE_CYC
) (
    input  wire logic                          sys_clk,
    input  wire logic                          sys_rst,
    input  wire logic [rf_tx_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [rf_tx_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          carrier_in,
    input  wire logic                          encoder_data,
    input  wire logic                          ext_modulation_in,
    output logic                               antenna_out_a,
    output logic                               antenna_out_b,
    output logic [5:0]                         drive_conductance,
    output logic                               modulating,
    output logic [2:0]                         encoder_rate,
    output logic [2:0]                         tx_bit_coding,
    output logic                               mode_reserved
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0]                  txc;
        logic [7:0]                  cw_cond;
        logic [7:0]                  mod_cond;
        logic [7:0]                  enc;
        logic                        ext_s1;
        logic                        ext_s2;
        logic                        aw_held;
        logic [rf_tx_pkg::ADDR_W-1:0] aw_addr;
        logic                        w_held;
        logic [7:0]                  w_data;
        logic                        w_strb0;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        rvalid;
        logic [31:0]                 rdata;
        logic [1:0]                  rresp;
        logic                        pulse_prev;
        logic [7:0]                  pulse_cnt;
        logic                        out_a;
        logic                        out_b;
        logic [5:0]                  cond;
        logic                        mod;
    } state_s;

    state_s st_r;
    state_s st_nxt;
    logic   mod_now;
    logic   carrier_b;
    logic   aw_take;
    logic   w_take;
    logic   ar_take;
    logic   do_write;

    // Handshake readies come straight from the held and valid flags
    assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
    assign s_axi_wready  = !st_r.w_held && !st_r.bvalid;
    assign s_axi_arready = !st_r.rvalid;
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;
    assign ar_take       = s_axi_arvalid && s_axi_arready;
    assign do_write      = st_r.aw_held && st_r.w_held && !st_r.bvalid;

    // Output ports from state
    assign s_axi_bvalid      = st_r.bvalid;
    assign s_axi_bresp       = st_r.bresp;
    assign s_axi_rvalid      = st_r.rvalid;
    assign s_axi_rdata       = st_r.rdata;
    assign s_axi_rresp       = st_r.rresp;
    assign antenna_out_a     = st_r.out_a;
    assign antenna_out_b     = st_r.out_b;
    assign drive_conductance = st_r.cond;
    assign modulating        = st_r.mod;
    assign encoder_rate      = st_r.enc[rf_tx_pkg::ENC_RATE_LSB +: 3];  // RL12
    assign tx_bit_coding     = st_r.enc[rf_tx_pkg::ENC_CODE_LSB +: 3];  // RL13

    // Flag codes that select no transmit mode
    assign mode_reserved = (encoder_rate == rf_tx_pkg::RATE_RSVD)       // RL12
        || (tx_bit_coding == rf_tx_pkg::CODE_RSVD_A)                    // RL13
        || (tx_bit_coding == rf_tx_pkg::CODE_RSVD_B);

    // Modulator input selection, single pulse overrides
    always_comb
    begin
        case (st_r.txc[rf_tx_pkg::TXC_SRC_LSB +: 2])  // RL1
            rf_tx_pkg::SRC_LOW:     mod_now = 1'b0;
            rf_tx_pkg::SRC_HIGH:    mod_now = 1'b1;
            rf_tx_pkg::SRC_ENCODER: mod_now = encoder_data;
            rf_tx_pkg::SRC_EXT_PIN: mod_now = st_r.ext_s2;
            default:                mod_now = 1'b0;
        endcase
        if (st_r.pulse_cnt != 8'h00)
        begin
            mod_now = 1'b1;  // RL10
        end
    end

    // Second carrier phase, inverted when the bit reads zero
    assign carrier_b = st_r.txc[rf_tx_pkg::TXC_B_INV] ? carrier_in : !carrier_in;  // RL3

    // Next-state logic
    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.ext_s1 = ext_modulation_in;
        st_nxt.ext_s2 = st_r.ext_s1;

        // Write address and data captured in either order
        if (aw_take)
        begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (w_take)
        begin
            st_nxt.w_held  = 1'b1;
            st_nxt.w_data  = s_axi_wdata[7:0];
            st_nxt.w_strb0 = s_axi_wstrb[0];
        end

        // Register write, reserved bits stay at their fixed values
        if (do_write)
        begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = rf_tx_pkg::RESP_OKAY;
            case (st_r.aw_addr[rf_tx_pkg::ADDR_W-1:2])
                rf_tx_pkg::IDX_TX_OUTPUT_CONTROL:
                    if (st_r.w_strb0)
                        st_nxt.txc = st_r.w_data & rf_tx_pkg::WMASK_TX_OUTPUT_CTRL;  // RL15
                rf_tx_pkg::IDX_CARRIER_COND:
                    if (st_r.w_strb0)
                        st_nxt.cw_cond = st_r.w_data & rf_tx_pkg::WMASK_COND;  // RL7
                rf_tx_pkg::IDX_MODULATION_COND:
                    if (st_r.w_strb0)
                        st_nxt.mod_cond = st_r.w_data & rf_tx_pkg::WMASK_COND;  // RL8
                rf_tx_pkg::IDX_ENCODER_RATE_CODE:
                    if (st_r.w_strb0)
                        st_nxt.enc = st_r.w_data & rf_tx_pkg::WMASK_ENCODER_CODE;  // RL11
                default:
                    st_nxt.bresp = rf_tx_pkg::RESP_SLVERR;
            endcase
        end
        if (st_r.bvalid && s_axi_bready)
        begin
            st_nxt.bvalid = 1'b0;
        end

        // Read path, unmapped addresses answer zero with an error
        if (ar_take)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = rf_tx_pkg::RESP_OKAY;
            case (s_axi_araddr[rf_tx_pkg::ADDR_W-1:2])
                rf_tx_pkg::IDX_TX_OUTPUT_CONTROL: st_nxt.rdata = {24'h000000, st_r.txc};
                rf_tx_pkg::IDX_CARRIER_COND:      st_nxt.rdata = {24'h000000, st_r.cw_cond};
                rf_tx_pkg::IDX_MODULATION_COND:   st_nxt.rdata = {24'h000000, st_r.mod_cond};
                rf_tx_pkg::IDX_ENCODER_RATE_CODE: st_nxt.rdata = {24'h000000, st_r.enc};
                default:
                begin
                    st_nxt.rdata = 32'h00000000;
                    st_nxt.rresp = rf_tx_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (st_r.rvalid && s_axi_rready)
        begin
            st_nxt.rvalid = 1'b0;
        end

        // Single pulse started on a rising trigger bit, never cleared here
        st_nxt.pulse_prev = st_r.enc[rf_tx_pkg::ENC_PULSE];
        if (st_r.enc[rf_tx_pkg::ENC_PULSE] && !st_r.pulse_prev)
        begin
            st_nxt.pulse_cnt = 8'(PULSE_CYCLES);  // RL10
        end
        else if (st_r.pulse_cnt != 8'h00)
        begin
            st_nxt.pulse_cnt = st_r.pulse_cnt - 8'h01;
        end

        // Antenna outputs and driver conductance
        st_nxt.mod = mod_now;
        if (!st_r.txc[rf_tx_pkg::TXC_A_EN])
            st_nxt.out_a = 1'b0;  // RL6
        else if (mod_now && st_r.txc[rf_tx_pkg::TXC_FORCE])
            st_nxt.out_a = 1'b0;  // RL2
        else
            st_nxt.out_a = carrier_in;  // RL6
        if (!st_r.txc[rf_tx_pkg::TXC_B_EN])
            st_nxt.out_b = 1'b0;  // RL5
        else if (st_r.txc[rf_tx_pkg::TXC_B_CW])
            st_nxt.out_b = carrier_b;  // RL4
        else if (mod_now && st_r.txc[rf_tx_pkg::TXC_FORCE])
            st_nxt.out_b = 1'b0;  // RL2
        else
            st_nxt.out_b = carrier_b;  // RL5
        if (mod_now && !st_r.txc[rf_tx_pkg::TXC_FORCE])
            st_nxt.cond = st_r.mod_cond[5:0];  // RL8
        else
            st_nxt.cond = st_r.cw_cond[5:0];  // RL7
    end

    // State register, constants only under reset
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r          <= '0;
            st_r.txc      <= rf_tx_pkg::RST_TX_OUTPUT_CONTROL;  // RL14
            st_r.cw_cond  <= rf_tx_pkg::RST_COND;               // RL14
            st_r.mod_cond <= rf_tx_pkg::RST_COND;               // RL14
            st_r.enc      <= rf_tx_pkg::RST_ENCODER_RATE_CODE;  // RL14
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_src_low;
        @(posedge sys_clk) disable iff (sys_rst)
        (st_r.txc[6:5] == rf_tx_pkg::SRC_LOW && st_r.pulse_cnt == 8'h00) |=> !modulating;
    endproperty
    a_src_low: assert property (p_src_low) else $error("low source modulated");  // RL1

    property p_src_enc;
        @(posedge sys_clk) disable iff (sys_rst)
        (st_r.txc[6:5] == rf_tx_pkg::SRC_ENCODER && st_r.pulse_cnt == 8'h00)
            |=> modulating == $past(encoder_data);
    endproperty
    a_src_enc: assert property (p_src_enc) else $error("encoder source not followed");  // RL1

    property p_force;
        @(posedge sys_clk) disable iff (sys_rst)
        (mod_now && st_r.txc[4]) |=> !antenna_out_a && drive_conductance == $past(st_r.cw_cond[5:0]);
    endproperty
    a_force: assert property (p_force) else $error("full ask not applied");  // RL2

    property p_b_cw;
        @(posedge sys_clk) disable iff (sys_rst)
        (st_r.txc[2:1] == 2'h3) |=> antenna_out_b == ($past(st_r.txc[3]) ~^ $past(carrier_in));
    endproperty
    a_b_cw: assert property (p_b_cw) else $error("second carrier phase wrong");  // RL3

    // Without continuous wave, forced full ASK gates the second carrier while modulating
    property p_b_mod;
        @(posedge sys_clk) disable iff (sys_rst)
        (st_r.txc[2:1] == 2'h1 && st_r.txc[4] && mod_now) |=> !antenna_out_b;
    endproperty
    a_b_mod: assert property (p_b_mod) else $error("second output not modulated");  // RL4

    property p_b_off;
        @(posedge sys_clk) disable iff (sys_rst)
        !st_r.txc[1] |=> !antenna_out_b;
    endproperty
    a_b_off: assert property (p_b_off) else $error("second output not constant");  // RL5

    property p_a_off;
        @(posedge sys_clk) disable iff (sys_rst)
        !st_r.txc[0] |=> !antenna_out_a;
    endproperty
    a_a_off: assert property (p_a_off) else $error("first output not constant");  // RL6

    property p_mod_cond;
        @(posedge sys_clk) disable iff (sys_rst)
        (mod_now && !st_r.txc[4]) |=> drive_conductance == $past(st_r.mod_cond[5:0]);
    endproperty
    a_mod_cond: assert property (p_mod_cond) else $error("modulation conductance unused");  // RL8

    property p_pulse;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(st_r.enc[7]) |=> ##1 modulating [*2];
    endproperty
    a_pulse: assert property (p_pulse) else $error("single pulse missing");  // RL10

    property p_pulse_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        (st_r.enc[7] && !do_write) |=> st_r.enc[7];
    endproperty
    a_pulse_hold: assert property (p_pulse_hold) else $error("pulse bit self cleared");  // RL11

    property p_reserved;
        @(posedge sys_clk) disable iff (sys_rst)
        do_write |=> !st_r.txc[7] && st_r.cw_cond[7:6] == 2'h0 && !st_r.enc[6]
            && st_r.mod_cond[7:6] == 2'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit changed");  // RL9

    property p_rsvd_flag;
        @(posedge sys_clk) disable iff (sys_rst)
        mode_reserved == (st_r.enc[5:3] == 3'h7
            || st_r.enc[2:1] == 2'h1);
    endproperty
    a_rsvd_flag: assert property (p_rsvd_flag) else $error("reserved mode flag wrong");  // RL12

    property p_wr_effect;
        @(posedge sys_clk) disable iff (sys_rst)
        (do_write && st_r.aw_addr[7:2] == rf_tx_pkg::IDX_TX_OUTPUT_CONTROL && st_r.w_strb0
            && st_r.w_data[0] == 1'b0) |=> ##1 !antenna_out_a;
    endproperty
    a_wr_effect: assert property (p_wr_effect) else $error("write not effective");  // RL15

    c_write: cover property (@(posedge sys_clk) disable iff (sys_rst) do_write);
    c_read:  cover property (@(posedge sys_clk) disable iff (sys_rst) ar_take);
    c_pulse: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(st_r.enc[7]));
    c_force: cover property (@(posedge sys_clk) disable iff (sys_rst) mod_now && st_r.txc[4]);
    c_ext:   cover property (@(posedge sys_clk) disable iff (sys_rst)
        st_r.txc[6:5] == rf_tx_pkg::SRC_EXT_PIN && modulating);
endmodule

// file: pkg/rf_tx_pkg.sv
// Register map, field layout, reset values and timing for the transmitter control bank
package rf_tx_pkg;
    // ****************************************
    // Register indices, byte address is four times the index
    // ****************************************
    localparam logic [5:0] IDX_TX_OUTPUT_CONTROL = 6'h11;
    localparam logic [5:0] IDX_CARRIER_COND      = 6'h12;
    localparam logic [5:0] IDX_MODULATION_COND   = 6'h13;
    localparam logic [5:0] IDX_ENCODER_RATE_CODE = 6'h14;
    localparam int         ADDR_W                = 8;

    // ****************************************
    // Reset values and writable-bit masks
    // ****************************************
    localparam logic [7:0] RST_TX_OUTPUT_CONTROL = 8'h58;
    localparam logic [7:0] RST_COND              = 8'h3F;
    localparam logic [7:0] RST_ENCODER_RATE_CODE = 8'h19;
    localparam logic [7:0] WMASK_TX_OUTPUT_CTRL  = 8'h7F;
    localparam logic [7:0] WMASK_COND            = 8'h3F;
    localparam logic [7:0] WMASK_ENCODER_CODE    = 8'hBF;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int TXC_SRC_LSB   = 5;
    localparam int TXC_FORCE     = 4;
    localparam int TXC_B_INV     = 3;
    localparam int TXC_B_CW      = 2;
    localparam int TXC_B_EN      = 1;
    localparam int TXC_A_EN      = 0;
    localparam int ENC_PULSE     = 7;
    localparam int ENC_RATE_LSB  = 3;
    localparam int ENC_CODE_LSB  = 0;

    // ****************************************
    // Modulator sources, rate and coding codes
    // ****************************************
    localparam logic [1:0] SRC_LOW     = 2'h0;
    localparam logic [1:0] SRC_HIGH    = 2'h1;
    localparam logic [1:0] SRC_ENCODER = 2'h2;
    localparam logic [1:0] SRC_EXT_PIN = 2'h3;
    localparam logic [2:0] RATE_RSVD   = 3'h7;
    localparam logic [2:0] CODE_RSVD_A = 3'h2;
    localparam logic [2:0] CODE_RSVD_B = 3'h3;

    // ****************************************
    // Bus responses and single pulse width
    // ****************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int         PULSE_NS    = 320;
    localparam int         CLK_NS      = 40;
    localparam int         PULSE_CYC   = (PULSE_NS + CLK_NS - 1) / CLK_NS;
endpackage

// file: test/antenna_net_model.sv
// Antenna network stand-in: free-running carrier phase and second-output activity counter
module antenna_net_model (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic antenna_out_a,
    input  wire logic antenna_out_b,
    output logic      carrier_in,
    output int        b_edges
);
    timeunit 1ns;
    timeprecision 1ns;

    logic b_last;

    // Carrier phase flips every cycle, transitions seen on the second output are counted
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            carrier_in <= 1'b0;
            b_last     <= 1'b0;
            b_edges    <= 0;
        end
        else
        begin
            carrier_in <= !carrier_in;
            b_last     <= antenna_out_b;
            if (b_last != antenna_out_b)
                b_edges <= b_edges + 1;
        end
    end
endmodule

// file: test/rf_transmitter_control_tb.sv
// Self-checking bench for the transmitter control register bank
module rf_transmitter_control_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // Constants and signals
    // ****************************************
    localparam int         P    = 4;
    localparam logic [7:0] A_TX = {rf_tx_pkg::IDX_TX_OUTPUT_CONTROL, 2'h0};
    localparam logic [7:0] A_CW = {rf_tx_pkg::IDX_CARRIER_COND, 2'h0};
    localparam logic [7:0] A_MD = {rf_tx_pkg::IDX_MODULATION_COND, 2'h0};
    localparam logic [7:0] A_EN = {rf_tx_pkg::IDX_ENCODER_RATE_CODE, 2'h0};
    localparam logic [1:0] OK   = rf_tx_pkg::RESP_OKAY;
    localparam logic [1:0] ERR  = rf_tx_pkg::RESP_SLVERR;
    logic        sys_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, carrier_in, encoder_data, ext_modulation_in, antenna_out_a;
    logic        antenna_out_b, modulating, mode_reserved;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [5:0]  drive_conductance;
    logic [2:0]  encoder_rate, tx_bit_coding;
    logic [7:0]  tv [8] = '{8'h00, 8'h03, 8'h0B, 8'h0F, 8'h33, 8'h37, 8'h3F, 8'h13};
    int          n_mismatch, n_compared, cyc, b_edges, cnt;
    logic        e;

    rf_transmitter_control #(.PULSE_CYCLES(P)) i_dut (.sys_clk, .sys_rst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .carrier_in,
        .encoder_data, .ext_modulation_in, .antenna_out_a, .antenna_out_b, .drive_conductance,
        .modulating, .encoder_rate, .tx_bit_coding, .mode_reserved);

    antenna_net_model i_net (.sys_clk, .sys_rst, .antenna_out_a, .antenna_out_b, .carrier_in,
        .b_edges);

    // ****************************************
    // Compare, bus and verdict tasks
    // ****************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        n_compared++;
        if (g !== x)
        begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h expected %h", $time, m, g, x);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid  <= s_axi_wvalid && !s_axi_wready;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        s_axi_bready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er, "write response");
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, {24'h0, d}, "read data");
        chk(s_axi_rresp, er, "read response");
    endtask

    // Antenna levels over both carrier phases for a written output control value
    task automatic outs(input logic [7:0] t);
        logic f;
        logic cb;
        repeat (2)
        begin
            @(negedge sys_clk);
            f  = t[4] && (t[6:5] == rf_tx_pkg::SRC_HIGH);
            cb = t[3] ? !carrier_in : carrier_in;
            chk(antenna_out_a, t[0] ? !f && !carrier_in : 1'b0, "out a");
            chk(antenna_out_b, t[1] ? cb && (t[2] || !f) : 1'b0, "out b");
            if (f)
                chk(drive_conductance, 6'h15, "forced conductance");
        end
    endtask

    task automatic give_verdict;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ****************************************
    // Clock, timeout and test sequence
    // ****************************************
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Cuts a hang short
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            give_verdict;
        end
    end

    // Register, source, output and pulse scenarios
    initial
    begin
        {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {s_axi_wstrb, encoder_data, ext_modulation_in} = 6'h3C;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(A_TX, 8'h58, OK);
        rd(A_CW, 8'h3F, OK);
        rd(A_MD, 8'h3F, OK);
        rd(A_EN, 8'h19, OK);
        chk({encoder_rate, tx_bit_coding}, 6'h19, "reset coder fields");
        wr(8'h40, 8'h5A, ERR);
        rd(8'h40, 8'h00, ERR);
        wr(A_CW, 8'h15, OK);
        wr(A_MD, 8'h2A, OK);
        rd(A_CW, 8'h15, OK);
        rd(A_MD, 8'h2A, OK);
        s_axi_wstrb <= 4'hE;
        wr(A_CW, 8'h3F, OK);
        s_axi_wstrb <= 4'hF;
        rd(A_CW, 8'h15, OK);
        for (int i = 0; i < 8; i++)
        begin
            wr(A_EN, {2'h0, i[2:0], i[2:0]}, OK);
            @(negedge sys_clk);
            chk(encoder_rate, i[2:0], "rate");
            chk(tx_bit_coding, i[2:0], "coding");
            chk(mode_reserved, i == 7 || i == 2 || i == 3, "reserved mode");
        end
        for (int s = 0; s < 4; s++)
        begin
            wr(A_TX, {1'b0, s[1:0], 5'h01}, OK);
            for (int lv = 0; lv < 2; lv++)
            begin
                @(posedge sys_clk);
                encoder_data      <= lv[0];
                ext_modulation_in <= lv[0];
                repeat (4) @(posedge sys_clk);
                @(negedge sys_clk);
                e = (s == 0) ? 1'b0 : (s == 1) ? 1'b1 : lv[0];
                chk(modulating, e, "modulator input");
                chk(drive_conductance, e ? 6'h2A : 6'h15, "conductance");
            end
        end
        foreach (tv[k])
        begin
            wr(A_TX, tv[k], OK);
            outs(tv[k]);
        end
        chk(b_edges > 0, 1'b1, "second output activity");
        wr(A_TX, 8'h01, OK);
        repeat (2)
        begin
            wr(A_EN, 8'h99, OK);
            cnt = 0;
            repeat (3 * P + 6)
            begin
                @(negedge sys_clk);
                cnt += (modulating === 1'b1);
            end
            chk(cnt, P, "pulse length");
            rd(A_EN, 8'h99, OK);
            wr(A_EN, 8'h19, OK);
        end
        give_verdict;
    end
endmodule
